// ### inc/tsb_pkg.sv
/*
  Package for the trigger sequencer broadcast block: register map,
  field positions, reset values, command and state types.
  Assumes a 32-bit AXI4-Lite register bus and a 100 MHz system clock.
*/
package tsb_pkg;

  localparam int unsigned CLK_FREQ_HZ = 100_000_000;

  // Register byte addresses
  localparam logic [7:0] OFS_CTRL_STATUS = 8'h00;
  localparam logic [7:0] OFS_BCAST_EN    = 8'h04;
  localparam logic [7:0] OFS_STEP_DELAY  = 8'h08;
  localparam logic [7:0] OFS_COMMAND     = 8'h0C;

  // Control/status field positions
  localparam int unsigned POS_WAIT_MODE  = 0;   // two bits
  localparam int unsigned POS_SW_TRIG    = 2;
  localparam int unsigned POS_SINGLE_STP = 3;
  localparam int unsigned POS_STEP_EN    = 4;
  localparam int unsigned POS_BUSY       = 8;
  localparam int unsigned POS_STATE      = 9;   // three bits

  // Broadcast enable field positions
  localparam int unsigned POS_ADC_LO     = 12;
  localparam int unsigned POS_CAP_LO     = 8;
  localparam int unsigned POS_OCCLK_LO   = 4;
  localparam int unsigned POS_OCTRG_LO   = 0;

  localparam logic [15:0] RST_BCAST_EN   = 16'h0000;
  localparam logic [15:0] RST_CTRL       = 16'h0000;
  localparam logic [15:0] RST_STEP_DELAY = 16'h0000;

  // Input wait mode encodings
  localparam logic [1:0] WM_LEVEL_NODLY = 2'h3;
  localparam logic [1:0] WM_LEVEL_DLY   = 2'h2;
  localparam logic [1:0] WM_EDGE_NODLY  = 2'h1;
  localparam logic [1:0] WM_EDGE_DLY    = 2'h0;

  // Command codes written to the command register
  localparam logic [3:0] CMD_NOP        = 4'h0;
  localparam logic [3:0] CMD_WAIT_HIGH  = 4'h1;
  localparam logic [3:0] CMD_WAIT_LOW   = 4'h2;
  localparam logic [3:0] CMD_BROADCAST  = 4'h3;
  localparam logic [3:0] CMD_CTRL_SWTRG = 4'h4;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_IN,
    ST_WAIT_SW,
    ST_DELAY,
    ST_BCAST
  } tsb_state_t;

endpackage

// ### verilog/tsb_top.sv
/*
  Trigger sequencer broadcast block: AXI4-Lite registers, a small
  command executor (wait for input, wait for software trigger, step
  delay, broadcast) and sixteen one-cycle trigger outputs.
  Assumes the wait input arrives asynchronously and the triggered
  peripherals sample the pulses on the same system clock.
*/
// Chosen here: register access over AXI4-Lite and the placing of the registers.
// Notes on behaviour
// - The two-bit input wait mode picks level or edge detect and whether the step delay follows.
// - Modes 11 and 01 skip the step delay regardless of the control command's setting.
// - Only the wait-high and wait-low commands look at the input wait mode.
// - The software trigger bit acts only while the software-trigger step option runs.
// - Bit 15 set makes a broadcast pulse trigger output 15; clear, it does not.
// - The 16-bit broadcast enable register is fully read/write and resets to zero.
// - Bits 15 down to 12 drive trigger outputs 15 down to 12 on a broadcast.
// - Bits 11 down to 8 pulse capture units 4 to 1 on a broadcast.
// - Each set compare clock bit in bits 7 to 4 gives one clock pulse on a broadcast.
`timescale 1ns/10ps
module tsb_top (
  input  wire logic        CLK_SYS_IN,
  input  wire logic        SRST_IN,
  input  wire logic        WAIT_INPUT_IN,
  input  wire logic [7:0]  S_AXI_AWADDR_IN,
  input  wire logic        S_AXI_AWVALID_IN,
  output logic             S_AXI_AWREADY_OUT,
  input  wire logic [31:0] S_AXI_WDATA_IN,
  input  wire logic [3:0]  S_AXI_WSTRB_IN,
  input  wire logic        S_AXI_WVALID_IN,
  output logic             S_AXI_WREADY_OUT,
  output logic [1:0]       S_AXI_BRESP_OUT,
  output logic             S_AXI_BVALID_OUT,
  input  wire logic        S_AXI_BREADY_IN,
  input  wire logic [7:0]  S_AXI_ARADDR_IN,
  input  wire logic        S_AXI_ARVALID_IN,
  output logic             S_AXI_ARREADY_OUT,
  output logic [31:0]      S_AXI_RDATA_OUT,
  output logic [1:0]       S_AXI_RRESP_OUT,
  output logic             S_AXI_RVALID_OUT,
  input  wire logic        S_AXI_RREADY_IN,
  output logic [15:0]      TRIGGER_OUT
);
  import tsb_pkg::*;

  tsb_state_t  state_reg;
  logic [15:0] bcast_en_reg;
  logic [15:0] ctrl_reg;
  logic [15:0] step_delay_reg;
  logic [15:0] delay_cnt_reg;
  logic [15:0] trig_reg;
  logic        sw_trig_reg;
  logic        in_meta_reg;
  logic        in_sync_reg;
  logic        in_prev_reg;
  logic        want_high_reg;
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;

  logic [1:0]  wait_mode;
  logic        step_en;
  logic        cmd_wr;
  logic        sw_set;
  logic        in_hit;

  assign wait_mode = ctrl_reg[POS_WAIT_MODE +: 2];
  assign step_en   = ctrl_reg[POS_STEP_EN];

  // Byte-lane merge used for the control, broadcast enable and step delay registers
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    logic [15:0] r;
    r = old;
    if (s[0]) begin
      r[7:0] = d[7:0];
    end
    if (s[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  function automatic logic known_addr(input logic [7:0] a);
    return (a == OFS_CTRL_STATUS) || (a == OFS_BCAST_EN) ||
           (a == OFS_STEP_DELAY)  || (a == OFS_COMMAND);
  endfunction

  // Write path: address and data may arrive in either order; each
  // channel is held in its own register until the other turns up

  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      aw_held_reg       <= 1'b0;
      w_held_reg        <= 1'b0;
      awaddr_reg        <= 8'h00;
      wdata_reg         <= 32'h0000_0000;
      wstrb_reg         <= 4'h0;
      S_AXI_AWREADY_OUT <= 1'b0;
      S_AXI_WREADY_OUT  <= 1'b0;
      S_AXI_BVALID_OUT  <= 1'b0;
      S_AXI_BRESP_OUT   <= RESP_OKAY;
    end else begin
      // Ready never waits for valid to drop, or a master that keeps
      // valid up after a response would wait for ever
      S_AXI_AWREADY_OUT <= !aw_held_reg && !S_AXI_BVALID_OUT;
      S_AXI_WREADY_OUT  <= !w_held_reg && !S_AXI_BVALID_OUT;
      if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
        aw_held_reg       <= 1'b1;
        awaddr_reg        <= S_AXI_AWADDR_IN;
        S_AXI_AWREADY_OUT <= 1'b0;
      end
      if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
        w_held_reg       <= 1'b1;
        wdata_reg        <= S_AXI_WDATA_IN;
        wstrb_reg        <= S_AXI_WSTRB_IN;
        S_AXI_WREADY_OUT <= 1'b0;
      end
      if (aw_held_reg && w_held_reg && !S_AXI_BVALID_OUT) begin
        aw_held_reg      <= 1'b0;
        w_held_reg       <= 1'b0;
        S_AXI_BVALID_OUT <= 1'b1;
        S_AXI_BRESP_OUT  <= known_addr(awaddr_reg) ? RESP_OKAY
                                                   : RESP_SLVERR;
      end else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
        S_AXI_BVALID_OUT <= 1'b0;
      end
    end
  end

  // Registers are written when both halves are held
  logic reg_wr;
  assign reg_wr = aw_held_reg && w_held_reg && !S_AXI_BVALID_OUT;

  // Commands act only on an accepted write, never on a bare valid,
  // so a write still stalled on the bus cannot start anything
  assign cmd_wr = reg_wr && (awaddr_reg == OFS_COMMAND) && wstrb_reg[0];

  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      bcast_en_reg   <= RST_BCAST_EN;
      ctrl_reg       <= RST_CTRL;
      step_delay_reg <= RST_STEP_DELAY;
    end else if (reg_wr) begin
      unique case (awaddr_reg)
        OFS_BCAST_EN:    bcast_en_reg <= merge16(bcast_en_reg, wdata_reg,
                                                 wstrb_reg);
        OFS_CTRL_STATUS: ctrl_reg <= merge16(ctrl_reg, wdata_reg,
                                             wstrb_reg) &
                                     16'h001B;
        OFS_STEP_DELAY:  step_delay_reg <= merge16(step_delay_reg,
                                                   wdata_reg, wstrb_reg);
        default: ;
      endcase
    end
  end

  // Software trigger is a write-one strobe, kept only while awaited
  assign sw_set = reg_wr && awaddr_reg == OFS_CTRL_STATUS &&
                  wstrb_reg[0] && wdata_reg[POS_SW_TRIG];

  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      sw_trig_reg <= 1'b0;
    end else if (state_reg == ST_WAIT_SW) begin
      sw_trig_reg <= sw_set;
    end else begin
      sw_trig_reg <= 1'b0;
    end
  end

  // Read path
  // Read data comes from the address seen at the handshake edge
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      S_AXI_ARREADY_OUT <= 1'b0;
      S_AXI_RVALID_OUT  <= 1'b0;
      S_AXI_RDATA_OUT   <= 32'h0000_0000;
      S_AXI_RRESP_OUT   <= RESP_OKAY;
    end else if (S_AXI_RVALID_OUT) begin
      S_AXI_ARREADY_OUT <= 1'b0;
      if (S_AXI_RREADY_IN) begin
        S_AXI_RVALID_OUT <= 1'b0;
      end
    end else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
      S_AXI_ARREADY_OUT <= 1'b0;
      S_AXI_RVALID_OUT  <= 1'b1;
      S_AXI_RRESP_OUT   <= known_addr(S_AXI_ARADDR_IN) ? RESP_OKAY
                                                       : RESP_SLVERR;
      unique case (S_AXI_ARADDR_IN)
        OFS_CTRL_STATUS: S_AXI_RDATA_OUT <= {16'h0000, 4'h0,
                                             3'(state_reg),
                                             state_reg != ST_IDLE,
                                             ctrl_reg[7:0]};
        OFS_BCAST_EN:    S_AXI_RDATA_OUT <= {16'h0000, bcast_en_reg};
        OFS_STEP_DELAY:  S_AXI_RDATA_OUT <= {16'h0000, step_delay_reg};
        default:         S_AXI_RDATA_OUT <= 32'h0000_0000;
      endcase
    end else begin
      S_AXI_ARREADY_OUT <= S_AXI_ARVALID_IN;
    end
  end

  // Wait input: two-stage synchroniser, then edge history
  // Only the second stage feeds logic; the first may be metastable
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      in_meta_reg <= 1'b0;
      in_sync_reg <= 1'b0;
      in_prev_reg <= 1'b0;
    end else begin
      in_meta_reg <= WAIT_INPUT_IN;
      in_sync_reg <= in_meta_reg;
      in_prev_reg <= in_sync_reg;
    end
  end

  // Level modes accept the present level; edge modes need a transition
  always_comb begin
    if (wait_mode[1]) begin
      in_hit = (in_sync_reg == want_high_reg);
    end else begin
      in_hit = (in_sync_reg == want_high_reg) &&
               (in_prev_reg != want_high_reg);
    end
  end

  // Command executor
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      state_reg     <= ST_IDLE;
      want_high_reg <= 1'b0;
      delay_cnt_reg <= 16'h0000;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (cmd_wr) begin
            unique case (wdata_reg[3:0])
              CMD_WAIT_HIGH: begin
                want_high_reg <= 1'b1;
                state_reg     <= ST_WAIT_IN;
              end
              CMD_WAIT_LOW: begin
                want_high_reg <= 1'b0;
                state_reg     <= ST_WAIT_IN;
              end
              CMD_BROADCAST:  state_reg <= ST_BCAST;
              CMD_CTRL_SWTRG: state_reg <= ST_WAIT_SW;
              default: ;
            endcase
          end
        end
        ST_WAIT_IN: begin
          if (in_hit) begin
            // Modes 11 and 01 leave with no delay
            if (wait_mode[0] || !step_en || step_delay_reg == 16'h0000)
            begin
              state_reg <= ST_IDLE;
            end else begin
              delay_cnt_reg <= step_delay_reg;
              state_reg     <= ST_DELAY;
            end
          end
        end
        ST_WAIT_SW: begin
          if (sw_trig_reg) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_DELAY: begin
          // Loaded with the step count, so exactly that many cycles
          delay_cnt_reg <= delay_cnt_reg - 16'h0001;
          if (delay_cnt_reg == 16'h0001) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_BCAST: state_reg <= ST_IDLE;
        default:  state_reg <= ST_IDLE;
      endcase
    end
  end

  // One-cycle pulses, each gated by its own enable bit
  // Registered so the peripherals never see a decode glitch
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_trig
      always_ff @(posedge CLK_SYS_IN) begin
        if (SRST_IN) begin
          trig_reg[g] <= 1'b0;
        end else begin
          trig_reg[g] <= (state_reg == ST_BCAST) &&
                         bcast_en_reg[g];
        end
      end
    end
  endgenerate

  assign TRIGGER_OUT = trig_reg;

endmodule // tsb_top

// ### bench/tsb_top_properties.sv
/* Checker for tsb_top: bus handshakes and trigger pulses.
   Assumes a bind to tsb_top, one clock, synchronous reset. */
`timescale 1ns/10ps
module tsb_top_properties (
  input wire logic        CLK_SYS_IN,
  input wire logic        SRST_IN,
  input wire logic        S_AXI_AWVALID_IN,
  input wire logic        S_AXI_AWREADY_OUT,
  input wire logic        S_AXI_WVALID_IN,
  input wire logic        S_AXI_WREADY_OUT,
  input wire logic [1:0]  S_AXI_BRESP_OUT,
  input wire logic        S_AXI_BVALID_OUT,
  input wire logic        S_AXI_BREADY_IN,
  input wire logic        S_AXI_ARVALID_IN,
  input wire logic        S_AXI_ARREADY_OUT,
  input wire logic [31:0] S_AXI_RDATA_OUT,
  input wire logic        S_AXI_RVALID_OUT,
  input wire logic        S_AXI_RREADY_IN,
  input wire logic [15:0] TRIGGER_OUT
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (SRST_IN);
  AST_RST_QUIET: assert property ($fell(SRST_IN) |->
    TRIGGER_OUT == 16'h0000 && !S_AXI_BVALID_OUT && !S_AXI_RVALID_OUT)
    else $error("output active straight out of reset");
  AST_TRIG_SINGLE: assert property (
    TRIGGER_OUT != 16'h0000 |=> TRIGGER_OUT == 16'h0000)
    else $error("trigger pulse longer than one cycle");
  AST_TRIG_AFTER_WRITE: assert property (
    TRIGGER_OUT != 16'h0000 |-> $past(S_AXI_BVALID_OUT))
    else $error("trigger without a command write just before");
  AST_R_ANSWER: assert property (
    S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT)
    else $error("read answer late");
  AST_B_ANSWER: assert property ($rose(S_AXI_BVALID_OUT) |->
    $past((S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) ||
          (S_AXI_WVALID_IN && S_AXI_WREADY_OUT), 2))
    else $error("write answer not timed to a handshake");
  AST_R_HOLD: assert property (
    S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=>
    S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT))
    else $error("read answer dropped or changed");
  AST_B_HOLD: assert property (
    S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=>
    S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT))
    else $error("write answer dropped or changed");
  AST_W_BLOCK: assert property (S_AXI_BVALID_OUT |->
    !S_AXI_AWREADY_OUT && !S_AXI_WREADY_OUT)
    else $error("write accepted while answer pending");
  AST_AR_BLOCK: assert property (
    S_AXI_RVALID_OUT |-> !S_AXI_ARREADY_OUT)
    else $error("read accepted while answer pending");
  cover property (TRIGGER_OUT == 16'hFFFF);
  cover property (S_AXI_BVALID_OUT && S_AXI_BRESP_OUT == 2'b10);
  cover property (S_AXI_RVALID_OUT && S_AXI_RREADY_IN);
endmodule // tsb_top_properties

// ### bench/tsb_periph_model.sv
/* Model of the triggered peripherals: records which lines pulsed.
   Assumes pulses on the system clock; clear_in empties the record. */
`timescale 1ns/10ps
module tsb_periph_model (
  input  wire logic        clk_in,
  input  wire logic        clear_in,
  input  wire logic [15:0] trig_in,
  output logic      [15:0] hits_out
);
  always_ff @(posedge clk_in) begin
    hits_out <= clear_in ? 16'h0000 : (hits_out | trig_in);
  end
endmodule // tsb_periph_model

// ### bench/tsb_top_test.sv
/* Self-checking bench for tsb_top: registers, wait modes, software
   trigger, broadcast. Assumes package, model and checker compiled. */
`timescale 1ns/10ps
module tsb_top_test;
  import tsb_pkg::*;
  logic        clk = 0, rst = 1, win = 0, clr = 0;
  logic        awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic        awr, wr, bv, arr, rv;
  logic [7:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0, rd;
  logic [3:0]  ws = 4'hF;
  logic [1:0]  br, rr;
  logic [15:0] trig, hits;
  int          failures = 0, comparisons = 0, cyc = 0;
  logic [15:0] rows [7] = '{16'h8000, 16'hF000, 16'h0F00, 16'h00F0,
                            16'h000F, 16'hA5C3, 16'h0000};
  tsb_top dut (.CLK_SYS_IN(clk), .SRST_IN(rst), .WAIT_INPUT_IN(win),
    .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv),
    .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(ws),
    .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wr), .S_AXI_BRESP_OUT(br),
    .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bready),
    .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv),
    .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rd), .S_AXI_RRESP_OUT(rr),
    .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rready), .TRIGGER_OUT(trig));
  tsb_periph_model u_periph (.clk_in(clk), .clear_in(clr),
    .trig_in(trig), .hits_out(hits));
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [15:0] d,
                     output logic [1:0] r);
    awa <= a;
    wd <= {16'h0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (bv !== 1'b1);
    r = br;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    ara <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    d = rd;
    r = rr;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  // Poll until not busy; returns elapsed cycles
  task automatic idle_time(output int t);
    logic [31:0] d;
    logic [1:0]  r;
    t = cyc;
    do begin
      axr(OFS_CTRL_STATUS, d, r);
    end while (d[POS_BUSY] !== 1'b0);
    t = cyc - t;
  endtask
  task automatic end_sim();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    end_sim();
  end
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          t;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Step delay enabled, mode 00: broadcast must still fire at once
    axw(OFS_CTRL_STATUS, 16'h0010, r);
    axw(OFS_STEP_DELAY, 16'h0028, r);
    foreach (rows[i]) begin
      axw(OFS_BCAST_EN, rows[i], r);
      axr(OFS_BCAST_EN, d, r);
      chk(d, {16'h0000, rows[i]});
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      axw(OFS_COMMAND, {12'h000, CMD_BROADCAST}, r);
      repeat (3) @(posedge clk);
      chk({16'h0000, hits}, {16'h0000, rows[i]});
    end
    for (int m = 0; m < 4; m++) begin
      axw(OFS_CTRL_STATUS, 16'h0010 | 16'(m), r);
      win <= 1'b0;
      axw(OFS_COMMAND, {12'h000, CMD_WAIT_HIGH}, r);
      repeat (6) @(posedge clk);
      win <= 1'b1;
      idle_time(t);
      chk({31'h0, t > 30}, {31'h0, m % 2 == 0});
      win <= 1'b0;
      repeat (4) @(posedge clk);
      // Input already low: only mode 11 ends here; mode 10 is still in its step delay
      axw(OFS_COMMAND, {12'h000, CMD_WAIT_LOW}, r);
      repeat (10) @(posedge clk);
      axr(OFS_CTRL_STATUS, d, r);
      chk({31'h0, d[POS_BUSY]}, {31'h0, m != 3});
      win <= 1'b1;
      repeat (4) @(posedge clk);
      win <= 1'b0;
      idle_time(t);
    end
    // Trigger while idle must not be remembered
    axw(OFS_CTRL_STATUS, 16'h0004, r);
    axw(OFS_COMMAND, {12'h000, CMD_CTRL_SWTRG}, r);
    axr(OFS_CTRL_STATUS, d, r);
    chk({28'h0, d[11:8]}, 32'h0000_0005);
    axw(OFS_BCAST_EN, 16'hFFFF, r);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    axw(OFS_COMMAND, {12'h000, CMD_BROADCAST}, r);
    repeat (3) @(posedge clk);
    chk({16'h0000, hits}, 32'h0000_0000);
    axw(OFS_CTRL_STATUS, 16'h0004, r);
    idle_time(t);
    axr(OFS_CTRL_STATUS, d, r);
    chk({28'h0, d[11:8]}, 32'h0000_0000);
    axr(8'h10, d, r);
    chk({d[29:0], r}, {30'h0, RESP_SLVERR});
    axw(8'h14, 16'hFFFF, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axr(OFS_BCAST_EN, d, r);
    chk(d, {16'h0000, RST_BCAST_EN});
    end_sim();
  end
endmodule // tsb_top_test
bind tsb_top tsb_top_properties u_props (.CLK_SYS_IN, .SRST_IN,
  .S_AXI_AWVALID_IN, .S_AXI_AWREADY_OUT, .S_AXI_WVALID_IN,
  .S_AXI_WREADY_OUT, .S_AXI_BRESP_OUT, .S_AXI_BVALID_OUT,
  .S_AXI_BREADY_IN, .S_AXI_ARVALID_IN, .S_AXI_ARREADY_OUT,
  .S_AXI_RDATA_OUT, .S_AXI_RVALID_OUT, .S_AXI_RREADY_IN, .TRIGGER_OUT);
